/* sim/dbp_probe_model.sv */
// Behavioural debug probe driving the serial test port.
module dbp_probe_model (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic oe_q;
	logic oe_ok = 1'b1;

	// ****************************************************************
	// Test clock stands still low between scans
	// ****************************************************************
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One 32 ns period; tdo taken just before the rising edge
	task automatic bit_cycle(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#16;
		q = tdo;
		oe_q = tdo_oe;
		tck = 1'b1;
		#16;
		tck = 1'b0;
	endtask

	// Leave the reset state for idle
	task automatic idle();
		logic q;
		bit_cycle(1'b0, 1'b0, q);
	endtask

	// Whole scan from idle back to idle, LSB first
	task automatic scan(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		bit_cycle(1'b1, tdi, q);
		if (ir) begin
			bit_cycle(1'b1, tdi, q);
		end
		bit_cycle(1'b0, tdi, q);
		bit_cycle(1'b0, tdi, q);
		for (int i = 0; i < n; i++) begin
			bit_cycle(i == n - 1, din[i], q);
			dout[i] = q;
			// Output must be driven for every shifted bit
			if (oe_q !== 1'b1) oe_ok = 1'b0;
		end
		// Released data line shows the inverse, never a stale bit
		bit_cycle(1'b1, ~din[n-1], q);
		bit_cycle(1'b0, ~din[n-1], q);
	endtask
endmodule

/* sim/dbp_top_assertions.sv */
// Concurrent checks on the core-side ports of the debug probe control block.
`include "dbp_consts.svh"
module dbp_chk #(
	parameter logic [31:0] LOCAL_VECTOR = `DBP_VECTOR_LOCAL
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic core_in_debug,
	input wire logic core_sleeping,
	input wire logic core_debug_taken,
	input wire logic core_probe_access_req,
	input wire logic core_probe_access_grant,
	input wire logic core_probe_access_error,
	input wire logic debug_exception_req,
	input wire logic core_wake,
	input wire logic pc_trace_stop,
	input wire logic [31:0] debug_vector,
	input wire logic core_soft_reset,
	input wire logic soft_reset_flag_set,
	input wire logic trace_clock_out,
	input wire logic trace_clock_out_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************************************
	// Core clock domain only
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_access_split: assert property (core_probe_access_req |-> core_probe_access_grant != core_probe_access_error)
		else $error("grant and error not exclusive");
	a_access_idle: assert property (!core_probe_access_req |-> !core_probe_access_grant && !core_probe_access_error)
		else $error("access answer without request");
	a_trace_quiet: assert property (!trace_clock_out_oe && !$past(trace_clock_out_oe) |-> !trace_clock_out)
		else $error("trace clock runs without probe");
	a_vector_sel: assert property (debug_vector == (trace_clock_out_oe ? `DBP_VECTOR_PROBE : LOCAL_VECTOR))
		else $error("debug vector wrong");
	a_wake_gate: assert property (core_wake == (debug_exception_req && core_sleeping))
		else $error("wake does not follow break");
	a_break_clear: assert property (core_debug_taken && debug_exception_req |=> !debug_exception_req)
		else $error("break flag not cleared");
	a_break_refused: assert property ($rose(debug_exception_req) |-> !$past(core_in_debug))
		else $error("break accepted in debug mode");
	a_reset_flag: assert property ($rose(core_soft_reset) |-> ##[0:1] soft_reset_flag_set)
		else $error("soft reset flag missing");
	a_stop_break: assert property (pc_trace_stop |-> ##[0:1] debug_exception_req)
		else $error("trace stop without break");
endmodule

bind dbp_top dbp_chk #(.LOCAL_VECTOR(LOCAL_VECTOR)) i_chk (.clk(clk), .rstn(rstn), .core_in_debug(core_in_debug),
	.core_sleeping(core_sleeping), .core_debug_taken(core_debug_taken), .core_probe_access_req(core_probe_access_req),
	.core_probe_access_grant(core_probe_access_grant), .core_probe_access_error(core_probe_access_error),
	.debug_exception_req(debug_exception_req), .core_wake(core_wake), .pc_trace_stop(pc_trace_stop),
	.debug_vector(debug_vector), .core_soft_reset(core_soft_reset), .soft_reset_flag_set(soft_reset_flag_set),
	.trace_clock_out(trace_clock_out), .trace_clock_out_oe(trace_clock_out_oe));

/* sim/dbp_top_test.sv */
// Self-checking bench for the debug probe control block.
`include "dbp_consts.svh"
module dbp_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic tck, tms, tdi, tdo, tdo_oe;
	logic debug_int_n = 1'b1;
	logic core_in_debug = 1'b0;
	logic core_sleeping = 1'b0;
	logic core_debug_taken = 1'b0;
	logic core_probe_access_req = 1'b0;
	logic grant, err, brk, wake, stop, srst, srf, tco, tco_oe;
	logic [31:0] vec;
	logic [31:0] rd;
	logic seen_stop = 1'b0;
	logic seen_srf = 1'b0;
	int n_mismatch = 0;
	int n_checks = 0;
	int n_cyc = 0;

	always #2.5 clk = ~clk;

	dbp_top i_dut (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.debug_int_n(debug_int_n), .core_in_debug(core_in_debug), .core_sleeping(core_sleeping),
		.core_debug_taken(core_debug_taken), .core_probe_access_req(core_probe_access_req),
		.core_probe_access_grant(grant), .core_probe_access_error(err), .debug_exception_req(brk),
		.core_wake(wake), .pc_trace_stop(stop), .debug_vector(vec), .core_soft_reset(srst),
		.soft_reset_flag_set(srf), .trace_clock_out(tco), .trace_clock_out_oe(tco_oe));
	dbp_probe_model i_probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

	// Sticky capture of one-cycle pulses, plus the hang limit
	always @(posedge clk) begin
		n_cyc <= n_cyc + 1;
		if (stop === 1'b1) seen_stop <= 1'b1;
		if (srf === 1'b1) seen_srf <= 1'b1;
		if (n_cyc == 30000) begin
			n_mismatch = n_mismatch + 1;
			$display("FAIL %0t timeout", $time);
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wclk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Select the control register, then one 32-bit scan; the capture lands in rd
	task automatic ctrl_scan(input logic [31:0] d);
		logic [31:0] ir_out;
		i_probe.scan(1'b1, 5, {27'h0, `DBP_CONTROL_SELECT}, ir_out);
		chk(ir_out[4:0], `DBP_IR_CAPTURE);
		i_probe.scan(1'b0, 32, d, rd);
		wclk(20);
	endtask

	// One core access attempt, answered in the same cycle
	task automatic access(input logic [1:0] exp);
		@(posedge clk) core_probe_access_req <= 1'b1;
		@(negedge clk) chk({grant, err}, exp);
		@(posedge clk) core_probe_access_req <= 1'b0;
	endtask

	task automatic take();
		@(posedge clk) core_debug_taken <= 1'b1;
		@(posedge clk) core_debug_taken <= 1'b0;
		wclk(3);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		chk(vec, `DBP_VECTOR_LOCAL);
		chk({srst, tco_oe, tco, brk}, 4'h0);
		access(2'b01);
	endtask

	// All ones while in debug: break dropped, unused bits stay 0
	task automatic t_all_ones();
		core_in_debug <= 1'b1;
		ctrl_scan(32'hffff_ffff);
		chk({srst, seen_srf, tco_oe, brk}, 4'he);
		chk(vec, `DBP_VECTOR_PROBE);
		access(2'b10);
		ctrl_scan(32'hffff_ffff);
		chk(rd[17:9], 9'h0c0);
	endtask

	task automatic t_release();
		ctrl_scan(32'h0000_0000);
		chk({srst, tco_oe, tco}, 3'h0);
		chk(vec, `DBP_VECTOR_LOCAL);
		ctrl_scan(32'h0000_0000);
		chk(rd[17:9], 9'h000);
	endtask

	task automatic t_break_write();
		core_in_debug <= 1'b0;
		core_sleeping <= 1'b1;
		ctrl_scan(32'h0000_1000);
		chk({brk, wake, seen_stop}, 3'h6);
		ctrl_scan(32'h0000_0000);
		chk(rd[17:9], 9'h008);
		take();
		chk({brk, wake}, 2'h0);
	endtask

	task automatic t_pin();
		debug_int_n <= 1'b0;
		wclk(20);
		chk({brk, seen_stop}, 2'h3);
		debug_int_n <= 1'b1;
		take();
		core_in_debug <= 1'b1;
		wclk(4);
		debug_int_n <= 1'b0;
		wclk(20);
		chk(brk, 1'b0);
		debug_int_n <= 1'b1;
		wclk(10);
		core_in_debug <= 1'b0;
	endtask

	// Data scan under another instruction goes to bypass
	task automatic t_bypass();
		i_probe.scan(1'b1, 5, {27'h0, `DBP_IR_RESET}, rd);
		i_probe.scan(1'b0, 32, 32'hffff_ffff, rd);
		wclk(20);
		chk({srst, tco_oe}, 2'h0);
		chk({i_probe.oe_ok, tdo_oe}, 2'b10);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		wclk(2);
		i_probe.idle();
		t_reset();
		t_all_ones();
		t_release();
		t_break_write();
		t_pin();
		t_bypass();
		finish_test();
	end
endmodule

/* src/dbp_consts.svh */
// Constants for the debug probe control block: bit positions, reset values, codes.
`ifndef DBP_CONSTS_SVH
`define DBP_CONSTS_SVH

// ****************************************************************
// Control register layout
// ****************************************************************
`define DBP_CTRL_W 32
`define DBP_BIT_BREAK 12
`define DBP_BIT_PROBE_PRESENT 15
`define DBP_BIT_SOFT_RESET 16
`define DBP_CTRL_RESET 32'h0000_0000

// ****************************************************************
// Instruction register and vectors
// ****************************************************************
`define DBP_IR_W 5
`define DBP_IR_CAPTURE 5'h01
`define DBP_IR_RESET 5'h1f
`define DBP_CONTROL_SELECT 5'h0a
`define DBP_VECTOR_PROBE 32'hbfc0_0480
`define DBP_VECTOR_LOCAL 32'hbfc0_0200

// ****************************************************************
// Synchroniser depth
// ****************************************************************
`define DBP_SYNC_DEPTH 3

`endif

/* src/dbp_pkg.sv */
// Types shared by the debug probe control block.
package dbp_pkg;

	// ****************************************************************
	// Test port controller states
	// ****************************************************************
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE,
		TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} dbp_tap_e;

	// Levels and events carried from the test clock to the core clock
	typedef struct packed {
		logic break_toggle;
		logic probe_present;
		logic core_soft_reset_request;
	} dbp_link_s;

endpackage

/* src/dbp_top.sv */
// Debug probe control register bits 9 to 17: break request, probe presence, core soft reset.
//
// What this block does
// - Shifting a 1 into control bit 12 raises a debug exception request to the core.
// - A break-driven debug exception wakes the core when it is asleep.
// - Bit 12 is cleared by hardware when the core takes the debug exception.
// - Break requests from a write or the pin are ignored while the core is in debug mode.
// - With bit 15 at 0 core accesses to probe memory are refused and end in a bus error.
// - With bit 15 at 0 the trace clock output stays disabled.
// - With bit 15 at 1 the debug exception vector sits at 0xbfc0_0480.
// - While bit 16 is 1 a soft reset is held on the core, released when it returns to 0.
// - A soft reset from bit 16 sets the soft reset flag of the core status register.
// - The soft reset request from bit 16 ignores the core reset mask.
// - Bits 9, 10, 11, 17 and reserved bits 13 and 14 always read 0.
// - The control register is reached only over the test port after the control-select instruction.
// - Shifting the control register writes its writable bits and returns status as it shifts out.
`include "dbp_consts.svh"

module dbp_top #(
	parameter logic [`DBP_IR_W-1:0] CONTROL_SELECT = `DBP_CONTROL_SELECT,
	parameter logic [31:0] LOCAL_VECTOR = `DBP_VECTOR_LOCAL
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic debug_int_n,
	input wire logic core_in_debug,
	input wire logic core_sleeping,
	input wire logic core_debug_taken,
	input wire logic core_probe_access_req,
	output logic core_probe_access_grant,
	output logic core_probe_access_error,
	output logic debug_exception_req,
	output logic core_wake,
	output logic pc_trace_stop,
	output logic [31:0] debug_vector,
	output logic core_soft_reset,
	output logic soft_reset_flag_set,
	output logic trace_clock_out,
	output logic trace_clock_out_oe
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	generate
		if (`DBP_IR_W < 2 || CONTROL_SELECT == `DBP_IR_RESET || LOCAL_VECTOR == `DBP_VECTOR_PROBE) begin : g_ir_check
			$error("instruction width below two, select code equals bypass code, or vectors coincide");
		end
	endgenerate

	// ****************************************************************
	// Test port controller (test clock domain)
	// ****************************************************************
	dbp_pkg::dbp_tap_e tap_reg;
	dbp_pkg::dbp_tap_e tap_next;
	logic [`DBP_IR_W-1:0] ir_shift_reg;
	logic [`DBP_IR_W-1:0] ir_reg;
	logic [`DBP_CTRL_W-1:0] dr_shift_reg;
	logic bypass_reg;
	logic probe_present_reg;
	logic soft_reset_req_reg;
	logic break_toggle_reg;
	logic [`DBP_SYNC_DEPTH-1:0] brk_stat_sync_reg;
	logic brk_stat_reg;
	logic tdo_reg;
	logic tdo_oe_reg;
	logic ctrl_selected;

	// Next state of the standard sixteen-state test controller
	always_comb begin
		tap_next = tap_reg;
		unique case (tap_reg)
			dbp_pkg::TAP_RESET: tap_next = tms ? dbp_pkg::TAP_RESET : dbp_pkg::TAP_IDLE;
			dbp_pkg::TAP_IDLE: tap_next = tms ? dbp_pkg::TAP_SEL_DR : dbp_pkg::TAP_IDLE;
			dbp_pkg::TAP_SEL_DR: tap_next = tms ? dbp_pkg::TAP_SEL_IR : dbp_pkg::TAP_CAP_DR;
			dbp_pkg::TAP_CAP_DR: tap_next = tms ? dbp_pkg::TAP_EXIT1_DR : dbp_pkg::TAP_SHIFT_DR;
			dbp_pkg::TAP_SHIFT_DR: tap_next = tms ? dbp_pkg::TAP_EXIT1_DR : dbp_pkg::TAP_SHIFT_DR;
			dbp_pkg::TAP_EXIT1_DR: tap_next = tms ? dbp_pkg::TAP_UPD_DR : dbp_pkg::TAP_PAUSE_DR;
			dbp_pkg::TAP_PAUSE_DR: tap_next = tms ? dbp_pkg::TAP_EXIT2_DR : dbp_pkg::TAP_PAUSE_DR;
			dbp_pkg::TAP_EXIT2_DR: tap_next = tms ? dbp_pkg::TAP_UPD_DR : dbp_pkg::TAP_SHIFT_DR;
			dbp_pkg::TAP_UPD_DR: tap_next = tms ? dbp_pkg::TAP_SEL_DR : dbp_pkg::TAP_IDLE;
			dbp_pkg::TAP_SEL_IR: tap_next = tms ? dbp_pkg::TAP_RESET : dbp_pkg::TAP_CAP_IR;
			dbp_pkg::TAP_CAP_IR: tap_next = tms ? dbp_pkg::TAP_EXIT1_IR : dbp_pkg::TAP_SHIFT_IR;
			dbp_pkg::TAP_SHIFT_IR: tap_next = tms ? dbp_pkg::TAP_EXIT1_IR : dbp_pkg::TAP_SHIFT_IR;
			dbp_pkg::TAP_EXIT1_IR: tap_next = tms ? dbp_pkg::TAP_UPD_IR : dbp_pkg::TAP_PAUSE_IR;
			dbp_pkg::TAP_PAUSE_IR: tap_next = tms ? dbp_pkg::TAP_EXIT2_IR : dbp_pkg::TAP_PAUSE_IR;
			dbp_pkg::TAP_EXIT2_IR: tap_next = tms ? dbp_pkg::TAP_UPD_IR : dbp_pkg::TAP_SHIFT_IR;
			dbp_pkg::TAP_UPD_IR: tap_next = tms ? dbp_pkg::TAP_SEL_DR : dbp_pkg::TAP_IDLE;
		endcase
	end

	// Controller state
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			tap_reg <= dbp_pkg::TAP_RESET;
		end else begin
			tap_reg <= tap_next;
		end
	end

	// Instruction register; test-logic reset falls back to the all-ones code
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			ir_shift_reg <= `DBP_IR_RESET;
			ir_reg <= `DBP_IR_RESET;
		end else begin
			unique case (tap_reg)
				dbp_pkg::TAP_RESET: begin
					ir_reg <= `DBP_IR_RESET;
				end
				dbp_pkg::TAP_CAP_IR: begin
					ir_shift_reg <= `DBP_IR_CAPTURE;
				end
				dbp_pkg::TAP_SHIFT_IR: begin
					ir_shift_reg <= {tdi, ir_shift_reg[`DBP_IR_W-1:1]};
				end
				dbp_pkg::TAP_UPD_IR: begin
					ir_reg <= ir_shift_reg;
				end
				default: begin
				end
			endcase
		end
	end

	// Control register only answers under its own instruction
	assign ctrl_selected = (ir_reg == CONTROL_SELECT);

	// Status captured for shifting out; unused and reserved bits stay 0
	function automatic logic [`DBP_CTRL_W-1:0] ctrl_image(
		input logic brk,
		input logic probe,
		input logic prst
	);
		logic [`DBP_CTRL_W-1:0] img;
		img = `DBP_CTRL_RESET;
		img[`DBP_BIT_BREAK] = brk;
		img[`DBP_BIT_PROBE_PRESENT] = probe;
		img[`DBP_BIT_SOFT_RESET] = prst;
		return img;
	endfunction

	// Data shift path: control register or one-bit bypass
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			dr_shift_reg <= `DBP_CTRL_RESET;
			bypass_reg <= 1'b0;
		end else if (tap_reg == dbp_pkg::TAP_CAP_DR) begin
			dr_shift_reg <= ctrl_image(brk_stat_reg, probe_present_reg, soft_reset_req_reg);
			bypass_reg <= 1'b0;
		end else if (tap_reg == dbp_pkg::TAP_SHIFT_DR) begin
			dr_shift_reg <= {tdi, dr_shift_reg[`DBP_CTRL_W-1:1]};
			bypass_reg <= tdi;
		end
	end

	// Writable bits change only at update under the control instruction
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			probe_present_reg <= 1'b0;
			soft_reset_req_reg <= 1'b0;
		end else if (tap_reg == dbp_pkg::TAP_UPD_DR && ctrl_selected) begin
			probe_present_reg <= dr_shift_reg[`DBP_BIT_PROBE_PRESENT];
			soft_reset_req_reg <= dr_shift_reg[`DBP_BIT_SOFT_RESET];
		end
	end

	// A written 1 in the break bit becomes one toggle for the core side
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			break_toggle_reg <= 1'b0;
		end else if (tap_reg == dbp_pkg::TAP_UPD_DR && ctrl_selected && dr_shift_reg[`DBP_BIT_BREAK]) begin
			break_toggle_reg <= ~break_toggle_reg;
		end
	end

	// Break flag brought back for capture; held value moves only when stages agree
	always_ff @(posedge tck or negedge rstn) begin
		if (!rstn) begin
			brk_stat_sync_reg <= '0;
			brk_stat_reg <= 1'b0;
		end else begin
			brk_stat_sync_reg <= {brk_stat_sync_reg[`DBP_SYNC_DEPTH-2:0], debug_exception_req};
			if (brk_stat_sync_reg[1] == brk_stat_sync_reg[2]) begin
				brk_stat_reg <= brk_stat_sync_reg[2];
			end
		end
	end

	// Output pin changes on the falling test clock, as probes sample on the rising one
	always_ff @(negedge tck or negedge rstn) begin
		if (!rstn) begin
			tdo_reg <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end else begin
			tdo_oe_reg <= (tap_reg == dbp_pkg::TAP_SHIFT_DR) || (tap_reg == dbp_pkg::TAP_SHIFT_IR);
			if (tap_reg == dbp_pkg::TAP_SHIFT_IR) begin
				tdo_reg <= ir_shift_reg[0];
			end else if (ctrl_selected) begin
				tdo_reg <= dr_shift_reg[0];
			end else begin
				tdo_reg <= bypass_reg;
			end
		end
	end

	assign tdo = tdo_reg;
	assign tdo_oe = tdo_oe_reg;

	// ****************************************************************
	// Crossing into the core clock domain
	// ****************************************************************
	dbp_pkg::dbp_link_s link_tck;
	dbp_pkg::dbp_link_s link_sync_reg [`DBP_SYNC_DEPTH];
	dbp_pkg::dbp_link_s link_held_reg;
	logic break_write_pulse;

	assign link_tck.break_toggle = break_toggle_reg;
	assign link_tck.probe_present = probe_present_reg;
	assign link_tck.core_soft_reset_request = soft_reset_req_reg;

	// Three-stage chain; first stage feeds only the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `DBP_SYNC_DEPTH; i++) begin
				link_sync_reg[i] <= '0;
			end
		end else begin
			link_sync_reg[0] <= link_tck;
			for (int i = 1; i < `DBP_SYNC_DEPTH; i++) begin
				link_sync_reg[i] <= link_sync_reg[i-1];
			end
		end
	end

	// Each bit is accepted once the second and third stages agree
	generate
		for (genvar b = 0; b < $bits(dbp_pkg::dbp_link_s); b++) begin : g_link_hold
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					link_held_reg[b] <= 1'b0;
				end else if (link_sync_reg[1][b] == link_sync_reg[2][b]) begin
					link_held_reg[b] <= link_sync_reg[2][b];
				end
			end
		end
	endgenerate

	// Toggle change means one write of 1 into the break bit
	assign break_write_pulse = (link_sync_reg[1].break_toggle == link_sync_reg[2].break_toggle)
		&& (link_sync_reg[2].break_toggle != link_held_reg.break_toggle);

	// ****************************************************************
	// Debug interrupt pin
	// ****************************************************************
	logic [`DBP_SYNC_DEPTH-1:0] dint_sync_reg;
	logic dint_level_reg;
	logic dint_assert_pulse;

	// Pin is asynchronous and active low; stored as an active-high level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dint_sync_reg <= '0;
			dint_level_reg <= 1'b0;
		end else begin
			dint_sync_reg <= {dint_sync_reg[`DBP_SYNC_DEPTH-2:0], ~debug_int_n};
			if (dint_sync_reg[1] == dint_sync_reg[2]) begin
				dint_level_reg <= dint_sync_reg[2];
			end
		end
	end

	// Only the assertion edge requests a break, so a held pin does not re-arm it
	assign dint_assert_pulse = (dint_sync_reg[1] == dint_sync_reg[2]) && dint_sync_reg[2] && !dint_level_reg;

	// ****************************************************************
	// Break request flag (core clock domain)
	// ****************************************************************
	logic break_reg;
	logic break_set;
	logic pc_trace_stop_reg;

	// Requests arriving in debug mode are dropped, not queued
	assign break_set = (break_write_pulse || dint_assert_pulse) && !core_in_debug;

	// Set wins over the clear from an exception taken in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			break_reg <= 1'b0;
		end else if (break_set) begin
			break_reg <= 1'b1;
		end else if (core_debug_taken) begin
			break_reg <= 1'b0;
		end
	end

	// Pin assertion ends program-counter trace with a one-cycle stop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_trace_stop_reg <= 1'b0;
		end else begin
			pc_trace_stop_reg <= dint_assert_pulse && !core_in_debug;
		end
	end

	assign debug_exception_req = break_reg;
	assign core_wake = break_reg && core_sleeping;
	assign pc_trace_stop = pc_trace_stop_reg;

	// ****************************************************************
	// Probe presence effects
	// ****************************************************************
	logic [31:0] vector_reg;
	logic trace_div_reg;
	logic trace_oe_reg;

	// Refused accesses are answered at once with a bus error
	assign core_probe_access_grant = core_probe_access_req && link_held_reg.probe_present;
	assign core_probe_access_error = core_probe_access_req && !link_held_reg.probe_present;

	// Vector follows probe presence
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vector_reg <= LOCAL_VECTOR;
		end else begin
			vector_reg <= link_held_reg.probe_present ? `DBP_VECTOR_PROBE : LOCAL_VECTOR;
		end
	end

	assign debug_vector = vector_reg;

	// Trace clock at half the core clock, parked low and undriven without a probe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trace_div_reg <= 1'b0;
			trace_oe_reg <= 1'b0;
		end else begin
			trace_oe_reg <= link_held_reg.probe_present;
			trace_div_reg <= link_held_reg.probe_present ? ~trace_div_reg : 1'b0;
		end
	end

	assign trace_clock_out = trace_div_reg;
	assign trace_clock_out_oe = trace_oe_reg;

	// ****************************************************************
	// Core soft reset
	// ****************************************************************
	logic soft_reset_reg;
	logic soft_flag_reg;

	// No reset mask input exists: the request is never gated
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			soft_reset_reg <= 1'b0;
		end else begin
			soft_reset_reg <= link_held_reg.core_soft_reset_request;
		end
	end

	// One pulse on the rising edge sets the core's soft reset flag
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			soft_flag_reg <= 1'b0;
		end else begin
			soft_flag_reg <= link_held_reg.core_soft_reset_request && !soft_reset_reg;
		end
	end

	assign core_soft_reset = soft_reset_reg;
	assign soft_reset_flag_set = soft_flag_reg;

endmodule
